/* brake_if.sv */
// Interfaces between the sequencer, its settings and its hold timer
`timescale 1ns/1ps
interface brake_cfg_if;
	import brake_pkg::*;
	logic [MODE_W-1:0] drive_control_mode_code;
	logic [SEL_W-1:0] relay_function_select;
	logic [SEL_W-1:0] output2_function_select;
	logic [CUR_W-1:0] brake_release_current_level;
	logic [DLY_W-1:0] brake_release_hold_delay;
	logic [FREQ_W-1:0] forward_release_frequency;
	logic [FREQ_W-1:0] reverse_release_frequency;
	logic [DLY_W-1:0] brake_engage_hold_delay;
	logic [FREQ_W-1:0] brake_engage_frequency;
	logic [STATE_W-1:0] state_code;
	logic released;
	logic enabled;
	modport regs (output drive_control_mode_code, relay_function_select,
		output2_function_select, brake_release_current_level,
		brake_release_hold_delay, forward_release_frequency,
		reverse_release_frequency, brake_engage_hold_delay,
		brake_engage_frequency, input state_code, released, enabled);
	modport seq (input drive_control_mode_code, relay_function_select,
		output2_function_select, brake_release_current_level,
		brake_release_hold_delay, forward_release_frequency,
		reverse_release_frequency, brake_engage_hold_delay,
		brake_engage_frequency, output state_code, released, enabled);
endinterface : brake_cfg_if

interface delay_timer_if;
	import brake_pkg::*;
	logic start;
	logic [DLY_W-1:0] steps;
	logic done;
	modport timer (input start, steps, output done);
	modport seq (output start, steps, input done);
endinterface : delay_timer_if

/* brake_pkg.sv */
// Shared constants and types of the motor brake sequencer
package brake_pkg;
	//==========================================================
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FREQ_W = 16;
	localparam int CUR_W = 11;
	localparam int DLY_W = 10;
	localparam int SEL_W = 5;
	localparam int MODE_W = 2;
	localparam int STATE_W = 3;
	//==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RELAY_SEL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OUT2_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_REL_CUR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_REL_DLY = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FWD_FREQ = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_REV_FREQ = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_ENG_DLY = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_ENG_FREQ = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
	//==========================================================
	// Status word fields
	localparam int STAT_RELEASED = 0;
	localparam int STAT_ENABLED = 1;
	localparam int STAT_STATE_LSB = 4;
	//==========================================================
	// Encodings and values after reset
	localparam logic [MODE_W-1:0] MODE_VF_STEADY = 2'h0;
	localparam logic [MODE_W-1:0] MODE_RST = 2'h1;
	localparam logic [SEL_W-1:0] FUNC_BRAKE = 5'h13;
	localparam logic [SEL_W-1:0] FUNC_RST = 5'h11;
	// Current in 0.1 %, delays in 0.01 s, frequencies in 0.01 Hz
	localparam logic [CUR_W-1:0] CUR_RST = 11'h1f4;
	localparam logic [CUR_W-1:0] CUR_MAX = 11'h708;
	localparam logic [DLY_W-1:0] DLY_RST = 10'h064;
	localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e8;
	localparam logic [FREQ_W-1:0] REL_FREQ_RST = 16'h0064;
	localparam logic [FREQ_W-1:0] ENG_FREQ_RST = 16'h00c8;
	//==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int DLY_STEP_MS = 10;
	localparam int DLY_TICK_CYCLES =
		(DLY_STEP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	//==========================================================
	// Sequencer states
	typedef enum logic [STATE_W-1:0] {
		ST_IDLE, ST_ACCEL, ST_CURRENT, ST_RELEASE,
		ST_RUN, ST_DECEL, ST_ENGAGE, ST_ZERO
	} seq_state_e;
endpackage : brake_pkg

/* brake_regs.sv */
// Settings and status registers of the brake sequencer
`timescale 1ns/1ps
module brake_regs (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [brake_pkg::ADDR_W-1:0] addr,
	input wire logic [brake_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [brake_pkg::DATA_W-1:0] rd_data,
	brake_cfg_if.regs cfg
);
	import brake_pkg::*;
	logic [DATA_W-1:0] status_w;

	// Out-of-range current and delay settings saturate rather than wrap
	function automatic logic [DATA_W-1:0] sat(input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] lim);
		sat = (v > lim) ? lim : v;
	endfunction : sat

	always_comb
	begin
		status_w = '0;
		status_w[STAT_RELEASED] = cfg.released;
		status_w[STAT_ENABLED] = cfg.enabled;
		status_w[STAT_STATE_LSB +: STATE_W] = cfg.state_code;
	end

	//==========================================================
	// Setting writes
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cfg.drive_control_mode_code <= MODE_RST;
			cfg.relay_function_select <= FUNC_RST;
			cfg.output2_function_select <= FUNC_RST;
			cfg.brake_release_current_level <= CUR_RST;
			cfg.brake_release_hold_delay <= DLY_RST;
			cfg.forward_release_frequency <= REL_FREQ_RST;
			cfg.reverse_release_frequency <= REL_FREQ_RST;
			cfg.brake_engage_hold_delay <= DLY_RST;
			cfg.brake_engage_frequency <= ENG_FREQ_RST;
		end
		else if (ce && wr_en)
		begin
			case (addr)
				OFS_MODE: cfg.drive_control_mode_code <= wr_data[MODE_W-1:0];
				OFS_RELAY_SEL: cfg.relay_function_select <= wr_data[SEL_W-1:0];
				OFS_OUT2_SEL: cfg.output2_function_select <= wr_data[SEL_W-1:0];
				OFS_REL_CUR: cfg.brake_release_current_level <=
					CUR_W'(sat(wr_data, DATA_W'(CUR_MAX)));
				OFS_REL_DLY: cfg.brake_release_hold_delay <=
					DLY_W'(sat(wr_data, DATA_W'(DLY_MAX)));
				OFS_FWD_FREQ: cfg.forward_release_frequency <= wr_data[FREQ_W-1:0];
				OFS_REV_FREQ: cfg.reverse_release_frequency <= wr_data[FREQ_W-1:0];
				OFS_ENG_DLY: cfg.brake_engage_hold_delay <=
					DLY_W'(sat(wr_data, DATA_W'(DLY_MAX)));
				OFS_ENG_FREQ: cfg.brake_engage_frequency <= wr_data[FREQ_W-1:0];
				default: ;
			endcase
		end
	end

	//==========================================================
	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rd_data <= '0;
		else if (ce)
		begin
			rd_data <= '0;
			if (rd_en)
			begin
				case (addr)
					OFS_MODE: rd_data <= DATA_W'(cfg.drive_control_mode_code);
					OFS_RELAY_SEL: rd_data <= DATA_W'(cfg.relay_function_select);
					OFS_OUT2_SEL: rd_data <= DATA_W'(cfg.output2_function_select);
					OFS_REL_CUR: rd_data <= DATA_W'(cfg.brake_release_current_level);
					OFS_REL_DLY: rd_data <= DATA_W'(cfg.brake_release_hold_delay);
					OFS_FWD_FREQ: rd_data <= DATA_W'(cfg.forward_release_frequency);
					OFS_REV_FREQ: rd_data <= DATA_W'(cfg.reverse_release_frequency);
					OFS_ENG_DLY: rd_data <= DATA_W'(cfg.brake_engage_hold_delay);
					OFS_ENG_FREQ: rd_data <= DATA_W'(cfg.brake_engage_frequency);
					OFS_STATUS: rd_data <= status_w;
					default: rd_data <= '0;
				endcase
			end
		end
	end
endmodule : brake_regs

/* hold_timer.sv */
// Hold-delay timer counting in 10 ms steps
`timescale 1ns/1ps
module hold_timer #(
	parameter int TICK_CYCLES = brake_pkg::DLY_TICK_CYCLES
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	delay_timer_if.timer tmr
);
	import brake_pkg::*;
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	logic [PRE_W-1:0] pre_r;
	logic [DLY_W-1:0] left_r;
	logic busy_r;

	// Done comes steps*TICK_CYCLES+1 edges after start
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pre_r <= '0;
			left_r <= '0;
			busy_r <= 1'b0;
			tmr.done <= 1'b0;
		end
		else if (ce)
		begin
			tmr.done <= 1'b0;
			if (tmr.start)
			begin
				pre_r <= '0;
				left_r <= tmr.steps;
				busy_r <= 1'b1;
			end
			else if (busy_r && left_r == '0)
			begin
				busy_r <= 1'b0;
				tmr.done <= 1'b1;
			end
			else if (busy_r && pre_r == PRE_W'(TICK_CYCLES - 1))
			begin
				pre_r <= '0;
				left_r <= left_r - 1'b1;
			end
			else if (busy_r)
				pre_r <= pre_r + 1'b1;
		end
	end
endmodule : hold_timer

/* motor_brake_sequencer.sv */
// Top of the external motor brake sequencer
//==========================================================
`timescale 1ns/1ps
module motor_brake_sequencer #(
	parameter int TICK_CYCLES = brake_pkg::DLY_TICK_CYCLES
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [brake_pkg::ADDR_W-1:0] addr,
	input wire logic [brake_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [brake_pkg::DATA_W-1:0] rd_data,
	input wire logic run_cmd,
	input wire logic reverse_cmd,
	input wire logic [brake_pkg::FREQ_W-1:0] out_freq,
	input wire logic [brake_pkg::CUR_W-1:0] motor_current,
	output logic relay_brake,
	output logic out2_brake,
	output logic freq_clamp_en,
	output logic [brake_pkg::FREQ_W-1:0] freq_clamp,
	output logic freq_hold,
	output logic freq_zero,
	output logic startup_inhibit
);
	import brake_pkg::*;

	brake_cfg_if cfg_bus();
	delay_timer_if tmr_bus();

	seq_state_e state_r;
	seq_state_e state_nxt;
	logic dir_r;
	logic dir_nxt;
	logic brake_en_w;
	logic release_nxt;
	logic [FREQ_W-1:0] rel_freq_w;
	logic relay_brake_r;
	logic out2_brake_r;
	logic freq_clamp_en_r;
	logic [FREQ_W-1:0] freq_clamp_r;
	logic freq_hold_r;
	logic freq_zero_r;
	logic startup_inhibit_r;

	function automatic logic sel_is_brake(input logic [SEL_W-1:0] sel);
		sel_is_brake = (sel == FUNC_BRAKE);
	endfunction : sel_is_brake

	//==========================================================
	// Submodules
	brake_regs u_regs (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.cfg(cfg_bus.regs)
	);

	hold_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.tmr(tmr_bus.timer)
	);

	//==========================================================
	// Enable and direction
	assign brake_en_w =
		(cfg_bus.drive_control_mode_code == MODE_VF_STEADY) &&
		(sel_is_brake(cfg_bus.relay_function_select) ||
		sel_is_brake(cfg_bus.output2_function_select));

	// Direction is frozen for the whole sequence once run starts
	assign dir_nxt = (state_r == ST_IDLE) ? reverse_cmd : dir_r;
	assign rel_freq_w = dir_nxt ? cfg_bus.reverse_release_frequency
		: cfg_bus.forward_release_frequency;

	//==========================================================
	// Sequence
	always_comb
	begin
		state_nxt = state_r;
		if (!brake_en_w)
			state_nxt = ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
					state_nxt = run_cmd ? ST_ACCEL : ST_IDLE;
				ST_ACCEL:
					state_nxt = !run_cmd ? ST_ZERO
						: (out_freq >= rel_freq_w) ? ST_CURRENT : ST_ACCEL;
				ST_CURRENT:
					state_nxt = !run_cmd ? ST_ZERO
						: (motor_current >= cfg_bus.brake_release_current_level)
						? ST_RELEASE : ST_CURRENT;
				ST_RELEASE:
					state_nxt = !run_cmd ? ST_DECEL
						: tmr_bus.done ? ST_RUN : ST_RELEASE;
				ST_RUN:
					state_nxt = run_cmd ? ST_RUN : ST_DECEL;
				ST_DECEL:
					state_nxt = run_cmd ? ST_RUN
						: (out_freq <= cfg_bus.brake_engage_frequency)
						? ST_ENGAGE : ST_DECEL;
				ST_ENGAGE:
					state_nxt = tmr_bus.done ? ST_ZERO : ST_ENGAGE;
				ST_ZERO:
					state_nxt = (out_freq == '0) ? ST_IDLE : ST_ZERO;
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	// Brake is open only from release through deceleration
	assign release_nxt = (state_nxt == ST_RELEASE) ||
		(state_nxt == ST_RUN) || (state_nxt == ST_DECEL);

	// Delay starts on entry to either hold state
	assign tmr_bus.start = ce && (state_nxt != state_r) &&
		((state_nxt == ST_RELEASE) || (state_nxt == ST_ENGAGE));
	assign tmr_bus.steps = (state_nxt == ST_ENGAGE)
		? cfg_bus.brake_engage_hold_delay : cfg_bus.brake_release_hold_delay;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			dir_r <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
		end
	end

	//==========================================================
	// Output flops, decoded from the next state except the clamp value and startup inhibit
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			relay_brake_r <= 1'b0;
			out2_brake_r <= 1'b0;
			freq_clamp_en_r <= 1'b0;
			freq_clamp_r <= REL_FREQ_RST;
			freq_hold_r <= 1'b0;
			freq_zero_r <= 1'b0;
			startup_inhibit_r <= 1'b0;
		end
		else if (ce)
		begin
			relay_brake_r <= release_nxt &&
				sel_is_brake(cfg_bus.relay_function_select);
			out2_brake_r <= release_nxt &&
				sel_is_brake(cfg_bus.output2_function_select);
			freq_clamp_en_r <= (state_nxt == ST_ACCEL) ||
				(state_nxt == ST_CURRENT);
			freq_clamp_r <= rel_freq_w;
			freq_hold_r <= (state_nxt == ST_CURRENT) ||
				(state_nxt == ST_RELEASE) || (state_nxt == ST_ENGAGE);
			freq_zero_r <= (state_nxt == ST_ZERO);
			startup_inhibit_r <= brake_en_w;
		end
	end

	assign relay_brake = relay_brake_r;
	assign out2_brake = out2_brake_r;
	assign freq_clamp_en = freq_clamp_en_r;
	assign freq_clamp = freq_clamp_r;
	assign freq_hold = freq_hold_r;
	assign freq_zero = freq_zero_r;
	assign startup_inhibit = startup_inhibit_r;

	assign cfg_bus.state_code = state_r;
	assign cfg_bus.released = relay_brake_r || out2_brake_r;
	assign cfg_bus.enabled = brake_en_w;

	//==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst || !ce);

	// Cycles spent in the present state, for hold-time checks
	logic [39:0] dwell_r;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			dwell_r <= '0;
		else if (ce)
			dwell_r <= (state_nxt != state_r) ? '0 : dwell_r + 40'h1;
	end

	sequence s_current_met;
		state_r == ST_CURRENT && run_cmd && brake_en_w &&
			motor_current >= cfg_bus.brake_release_current_level;
	endsequence

	sequence s_released;
		state_r == ST_RELEASE && freq_hold_r && !freq_clamp_en_r &&
			(relay_brake_r || out2_brake_r);
	endsequence

	sequence s_engage_point;
		state_r == ST_DECEL && !run_cmd && brake_en_w &&
			out_freq <= cfg_bus.brake_engage_frequency;
	endsequence

	sequence s_engaged;
		state_r == ST_ENGAGE && freq_hold_r &&
			!relay_brake_r && !out2_brake_r;
	endsequence

	mode_gate_a: assert property (
		cfg_bus.drive_control_mode_code != MODE_VF_STEADY |=>
		state_r == ST_IDLE && !freq_hold_r && !freq_zero_r && !relay_brake_r)
		else $error("sequence active outside steady mode");

	select_gate_a: assert property (
		!sel_is_brake(cfg_bus.relay_function_select) |=> !relay_brake_r)
		else $error("relay driven without brake function");

	startup_inhibit_a: assert property (
		state_r != ST_IDLE |-> startup_inhibit_r)
		else $error("startup braking not suppressed");

	release_clamp_a: assert property (
		state_r == ST_IDLE && run_cmd && brake_en_w |=>
		state_r == ST_ACCEL && freq_clamp_en_r && !relay_brake_r &&
		freq_clamp_r == ($past(reverse_cmd)
		? $past(cfg_bus.reverse_release_frequency)
		: $past(cfg_bus.forward_release_frequency)))
		else $error("wrong release frequency clamp");

	release_current_a: assert property (s_current_met |=> s_released)
		else $error("brake not released at release current");

	release_wait_a: assert property (
		state_r == ST_RELEASE && run_cmd && brake_en_w && !tmr_bus.done
		|=> s_released)
		else $error("release hold ended early");

	release_time_a: assert property (
		state_r == ST_RELEASE && state_nxt == ST_RUN |->
		dwell_r == 40'(cfg_bus.brake_release_hold_delay) *
		40'(TICK_CYCLES) + 40'h1 ##1 !freq_hold_r && !freq_clamp_en_r)
		else $error("release hold time wrong");

	engage_point_a: assert property (s_engage_point |=> s_engaged)
		else $error("brake not engaged at engage frequency");

	engage_time_a: assert property (
		state_r == ST_ENGAGE && state_nxt == ST_ZERO |->
		dwell_r == 40'(cfg_bus.brake_engage_hold_delay) *
		40'(TICK_CYCLES) + 40'h1 ##1 freq_zero_r && !freq_hold_r)
		else $error("engage hold time wrong");

	stopped_engaged_a: assert property (
		state_r == ST_IDLE || state_r == ST_ZERO |->
		!relay_brake_r && !out2_brake_r)
		else $error("brake open while stopped");

	accel_closed_a: assert property (
		state_r == ST_ACCEL && run_cmd && brake_en_w |=>
		freq_clamp_en_r && !relay_brake_r && !out2_brake_r)
		else $error("brake opened before release frequency");

	run_open_a: assert property (
		state_r == ST_RUN && run_cmd && brake_en_w |=>
		state_r == ST_RUN && (relay_brake_r || out2_brake_r) &&
		!freq_hold_r && !freq_clamp_en_r)
		else $error("acceleration blocked after release");

	decel_open_a: assert property (
		state_r == ST_RUN && !run_cmd && brake_en_w |=>
		state_r == ST_DECEL && !freq_hold_r &&
		(relay_brake_r || out2_brake_r))
		else $error("brake closed above engage frequency");

	zero_force_a: assert property (
		state_r == ST_ZERO && brake_en_w && out_freq != '0 |=>
		freq_zero_r && !freq_hold_r)
		else $error("frequency not forced to zero");

	disable_close_a: assert property (
		!brake_en_w |=> !relay_brake_r && !out2_brake_r &&
		!freq_clamp_en_r && !freq_hold_r)
		else $error("brake open while sequence disabled");
endmodule : motor_brake_sequencer

/* motor_brake_sequencer_tb_top.sv */
// Self-checking testbench of the motor brake sequencer
`timescale 1ns/1ps
module motor_brake_sequencer_tb_top;
	import brake_pkg::*;
	localparam int TICK = 4;
	localparam int REL_DLY = 2;
	localparam int ENG_DLY = 3;
	logic clock, sys_rst, ce, wr_en, rd_en, run_cmd, reverse_cmd, rd_seen;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [FREQ_W-1:0] out_freq, freq_clamp;
	logic [CUR_W-1:0] motor_current, load, level;
	logic relay_brake, out2_brake, freq_clamp_en, freq_hold, freq_zero;
	logic startup_inhibit;
	logic [1:0] brk_prev;
	logic [31:0] rd_q[$];
	logic [1:0] brk_q[$];
	int miscompares, total_checks, n;
	integer seed;
	logic [7:0] ofs_t[10] = '{OFS_MODE, OFS_RELAY_SEL, OFS_OUT2_SEL,
		OFS_REL_CUR, OFS_REL_DLY, OFS_FWD_FREQ, OFS_REV_FREQ, OFS_ENG_DLY,
		OFS_ENG_FREQ, OFS_STATUS};
	logic [31:0] rst_t[10] = '{32'h1, 32'h11, 32'h11, 32'h1f4, 32'h64,
		32'h64, 32'h64, 32'h64, 32'hc8, 32'h0};
	logic [31:0] mode_t[5] = '{32'h1, 32'h2, 32'h3, 32'h0, 32'h0};
	logic [31:0] rsel_t[5] = '{32'h13, 32'h13, 32'h13, 32'h11, 32'h12};
	logic [31:0] osel_t[5] = '{32'h11, 32'h11, 32'h11, 32'h11, 32'h0};
	//==========================================================
	// Clock, design and far side
	initial clock = 1'b0;
	always #5 clock = ~clock;
	motor_brake_sequencer #(.TICK_CYCLES(TICK)) dut (.clock(clock),
		.sys_rst(sys_rst), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .run_cmd(run_cmd),
		.reverse_cmd(reverse_cmd), .out_freq(out_freq),
		.motor_current(motor_current), .relay_brake(relay_brake),
		.out2_brake(out2_brake), .freq_clamp_en(freq_clamp_en),
		.freq_clamp(freq_clamp), .freq_hold(freq_hold),
		.freq_zero(freq_zero), .startup_inhibit(startup_inhibit));
	motor_plant_model plant (.clock(clock), .sys_rst(sys_rst),
		.run_cmd(run_cmd), .clamp_en(freq_clamp_en), .clamp(freq_clamp),
		.hold(freq_hold), .zero(freq_zero), .load(load),
		.out_freq(out_freq), .motor_current(motor_current));
	//==========================================================
	// Comparison, bus and closing tasks
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		rd_q.push_back(e);
		@(posedge clock);
		rd_en <= 1'b0;
	endtask : rd
	task automatic settle(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : settle
	task automatic end_of_test;
		chk("pending_results", 32'h0, 32'(rd_q.size() + brk_q.size()));
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	//==========================================================
	// Result watcher: read data and brake output changes
	initial brk_prev = 2'b00;
	initial rd_seen = 1'b0;
	always @(posedge clock)
	begin
		if (rd_seen)
			chk("rd_data", rd_q.size() ? rd_q.pop_front() : 32'hx, rd_data);
		rd_seen = rd_en;
		if (!sys_rst && {out2_brake, relay_brake} !== brk_prev)
			chk("brake_outputs", brk_q.size() ? brk_q.pop_front() : 2'bxx,
				{out2_brake, relay_brake});
		brk_prev = {out2_brake, relay_brake};
	end
	//==========================================================
	// Full release and engage cycle in one direction
	task automatic brake_cycle(input logic rev);
		level = 11'h64 + 11'($random(seed) & 32'h1ff);
		wr(OFS_MODE, 32'h0);
		wr(OFS_RELAY_SEL, rev ? 32'h11 : 32'h13);
		wr(OFS_OUT2_SEL, rev ? 32'h13 : 32'h11);
		wr(OFS_REL_CUR, 32'(level));
		wr(OFS_REL_DLY, 32'(REL_DLY));
		wr(OFS_ENG_DLY, 32'(ENG_DLY));
		wr(OFS_FWD_FREQ, 32'h64);
		wr(OFS_REV_FREQ, 32'h96);
		wr(OFS_ENG_FREQ, 32'hc8);
		brk_q.push_back(rev ? 2'b10 : 2'b01);
		brk_q.push_back(2'b00);
		rd(OFS_STATUS, 32'h2);
		@(posedge clock);
		load <= level - 11'h1;
		reverse_cmd <= rev;
		run_cmd <= 1'b1;
		settle(3);
		chk("startup_inhibit", 32'h1, 32'(startup_inhibit));
		settle(60);
		chk("freq_clamp", rev ? 32'h96 : 32'h64, 32'(freq_clamp));
		chk("out_freq", rev ? 32'h96 : 32'h64, 32'(out_freq));
		chk("brake_low_current", 32'h0, 32'({out2_brake, relay_brake}));
		@(posedge clock);
		load <= level;
		n = 0;
		while (!(relay_brake | out2_brake) && n < 20)
		begin
			settle(1);
			n++;
		end
		chk("release_latency", 32'h1, 32'(n >= 1 && n <= 2));
		n = 0;
		while (freq_hold && n < 200)
		begin
			settle(1);
			n++;
		end
		chk("release_hold", 32'(REL_DLY * TICK + 2), 32'(n));
		chk("held_freq", rev ? 32'h96 : 32'h64, 32'(out_freq));
		settle(80);
		chk("run_freq", 32'h258, 32'(out_freq));
		rd(OFS_STATUS, 32'h43);
		@(posedge clock);
		run_cmd <= 1'b0;
		n = 0;
		while ((relay_brake | out2_brake) && n < 200)
		begin
			settle(1);
			n++;
		end
		chk("engage_freq", 32'h1, 32'(out_freq <= 16'hc8 && out_freq > 16'haa));
		chk("engage_hold_on", 32'h1, 32'(freq_hold));
		n = 0;
		while (!freq_zero && n < 200)
		begin
			settle(1);
			n++;
		end
		chk("engage_hold", 32'(ENG_DLY * TICK + 2), 32'(n));
		settle(10);
		chk("zero_freq", 32'h0, 32'(out_freq));
		chk("brake_stopped", 32'h0, 32'({out2_brake, relay_brake}));
		rd(OFS_STATUS, 32'h2);
	endtask : brake_cycle
	//==========================================================
	// Main sequence
	initial
	begin
		seed = 32'he1fe;
		sys_rst = 1'b1;
		ce = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = '0;
		wr_data = '0;
		run_cmd = 1'b0;
		reverse_cmd = 1'b0;
		load = '0;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		settle(1);
		chk("brake_after_reset", 32'h0, 32'({out2_brake, relay_brake}));
		chk("clamp_after_reset", 32'h64, 32'(freq_clamp));
		for (int i = 0; i < 10; i++)
			rd(ofs_t[i], rst_t[i]);
		wr(OFS_REL_CUR, 32'h7ff);
		rd(OFS_REL_CUR, 32'h708);
		wr(OFS_ENG_DLY, 32'h3ff);
		rd(OFS_ENG_DLY, 32'h3e8);
		wr(8'h28, 32'h5a);
		rd(8'h28, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_MODE, mode_t[i]);
			wr(OFS_RELAY_SEL, rsel_t[i]);
			wr(OFS_OUT2_SEL, osel_t[i]);
			@(posedge clock);
			run_cmd <= 1'b1;
			load <= 11'(32'h708 & $random(seed));
			settle(80);
			chk("brake_inactive", 32'h0, 32'({out2_brake, relay_brake}));
			chk("clamp_inactive", 32'h0, 32'(freq_clamp_en));
			chk("inhibit_inactive", 32'h0, 32'(startup_inhibit));
			rd(OFS_STATUS, 32'h0);
			@(posedge clock);
			run_cmd <= 1'b0;
			settle(80);
		end
		brake_cycle(1'b0);
		brake_cycle(1'b1);
		settle(5);
		end_of_test;
	end
	//==========================================================
	// Watchdog against a hung sequence
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		end_of_test;
	end
endmodule : motor_brake_sequencer_tb_top

/* motor_plant_model.sv */
// Behavioural drive output stage and motor facing the brake sequencer
`timescale 1ns/1ps
module motor_plant_model #(
	parameter int RUN_FREQ = 600,
	parameter int STEP = 10
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic run_cmd,
	input wire logic clamp_en,
	input wire logic [brake_pkg::FREQ_W-1:0] clamp,
	input wire logic hold,
	input wire logic zero,
	input wire logic [brake_pkg::CUR_W-1:0] load,
	output logic [brake_pkg::FREQ_W-1:0] out_freq,
	output logic [brake_pkg::CUR_W-1:0] motor_current
);
	import brake_pkg::*;
	logic [FREQ_W-1:0] tgt;
	//==========================================================
	// Ramp target and frequency ramp
	always_comb
	begin
		tgt = run_cmd ? FREQ_W'(RUN_FREQ) : '0;
		if (clamp_en && tgt > clamp)
			tgt = clamp;
	end
	// Ramp stops exactly on target so clamp levels are hit precisely
	always_ff @(posedge clock)
	begin
		if (sys_rst || zero)
			out_freq <= '0;
		else if (!hold && out_freq + STEP <= tgt)
			out_freq <= out_freq + FREQ_W'(STEP);
		else if (!hold && out_freq > tgt + STEP)
			out_freq <= out_freq - FREQ_W'(STEP);
		else if (!hold)
			out_freq <= tgt;
	end
	//==========================================================
	// Current flows only while the stator is fed
	assign motor_current = (out_freq != '0) ? load : '0;
endmodule : motor_plant_model
